// ==== src/gate_drive_sequencer.sv ====
`timescale 1ns/10ps
module gate_drive_sequencer #(
  parameter int unsigned LOW_SIDE_OFF_CYCLES = gate_seq_pkg::LOW_SIDE_OFF_CYC,
  parameter int unsigned HIGH_SIDE_OFF_CYCLES = gate_seq_pkg::HIGH_SIDE_OFF_CYC,
  parameter int unsigned HIGH_SIDE_ON_CYCLES = gate_seq_pkg::HIGH_SIDE_ON_CYC,
  parameter int unsigned LOW_SIDE_ON_CYCLES = gate_seq_pkg::LOW_SIDE_ON_CYC,
  parameter int unsigned BLANK_CYCLES = gate_seq_pkg::BLANK_CYC,
  parameter int unsigned CALIBRATION_CYCLES = gate_seq_pkg::CALIBRATION_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire gate_seq_pkg::level_t pwm_level_i,
  input wire gate_seq_pkg::level_t skip_mode_n_i,
  input wire logic driver_enable_n_i,
  input wire logic driver_enable_open_i,
  input wire logic supply_ok_i,
  input wire gate_seq_pkg::monitor_t monitor_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output gate_seq_pkg::gate_cmd_t gate_o,
  output logic pwm_bias_en_o,
  output logic zero_current_pwm_mode_o,
  output logic calibrating_o
);

  localparam int CW = 20;

  // Counters are CW bits wide and the gate delays stay within eight bits;
  // lengths that do not fit, or are zero, cannot be served
  if (CALIBRATION_CYCLES >= (1 << CW) || BLANK_CYCLES >= (1 << CW) || LOW_SIDE_OFF_CYCLES == 0 ||
      HIGH_SIDE_OFF_CYCLES == 0 || HIGH_SIDE_ON_CYCLES == 0 || LOW_SIDE_ON_CYCLES == 0 ||
      BLANK_CYCLES == 0 || CALIBRATION_CYCLES == 0 || LOW_SIDE_OFF_CYCLES > 255 ||
      HIGH_SIDE_OFF_CYCLES > 255 || HIGH_SIDE_ON_CYCLES > 255 || LOW_SIDE_ON_CYCLES > 255)
  begin : gen_bad_length
    $error("gate_drive_sequencer: timer length out of range");
  end

  typedef enum logic [2:0] {
    ST_OFF,
    ST_LS_ON,
    ST_LS_TURNOFF,
    ST_HS_WAIT,
    ST_HS_ON,
    ST_HS_TURNOFF,
    ST_LS_WAIT,
    ST_ZCD_WATCH
  } phase_t;

  // Two-flop synchronisers for pin-side inputs
  logic [10:0] sync_a;
  logic [10:0] sync_b;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync_a <= 11'h000;
      sync_b <= 11'h000;
    end
    else
    begin
      sync_a <= {pwm_level_i, skip_mode_n_i, driver_enable_n_i, driver_enable_open_i, supply_ok_i, monitor_i};
      sync_b <= sync_a;
    end
  end

  gate_seq_pkg::level_t pwm;
  gate_seq_pkg::level_t skip;
  logic enable_pin;
  logic enable_open;
  logic supply_ok;
  gate_seq_pkg::monitor_t mon;
  assign pwm = gate_seq_pkg::level_t'(sync_b[10:9]); // R19
  assign skip = gate_seq_pkg::level_t'(sync_b[8:7]); // R19
  assign enable_pin = sync_b[6];
  assign enable_open = sync_b[5];
  assign supply_ok = sync_b[4];
  assign mon = gate_seq_pkg::monitor_t'(sync_b[3:0]);

  // Register file
  logic [31:0] control;
  logic force_off;
  assign force_off = control[gate_seq_pkg::CTRL_FORCE_OFF_BIT];

  // Driver enabled only with supply good, enable pin driven high, not forced
  logic enabled;
  assign enabled = supply_ok && enable_pin && !enable_open && !force_off; // R13 R15 R18

  // Skip-mode codes that turn zero-current handling on; mid acts as high
  function automatic logic zcd_code(input gate_seq_pkg::level_t s);
    return (s == gate_seq_pkg::LEVEL_HIGH) || (s == gate_seq_pkg::LEVEL_MID);
  endfunction

  // Skip-mode decode: mid acts as high apart from bias
  logic zcd_mode;
  assign zcd_mode = zcd_code(skip); // R6 R16
  // Bias engaged only in skip mid; disconnected otherwise
  logic bias_on;
  assign bias_on = (skip == gate_seq_pkg::LEVEL_MID); // R11 R12

  // Conduction status from gate levels and switch node
  logic ls_conducting;
  logic hs_conducting;
  assign ls_conducting = mon.low_side_gate_level; // R5
  assign hs_conducting = mon.high_side_gate_level || mon.switch_node; // R5

  // Calibration on every rising edge of the enable input
  logic enable_prev;
  logic [CW-1:0] cal_cnt;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enable_prev <= 1'b0;
      cal_cnt <= '0;
    end
    else
    begin
      enable_prev <= enable_pin;
      if (enable_pin && !enable_prev)
        cal_cnt <= CW'(CALIBRATION_CYCLES); // R9
      else if (cal_cnt != '0)
        cal_cnt <= cal_cnt - CW'(1);
    end
  end
  logic cal_busy;
  assign cal_busy = (cal_cnt != '0);

  // Mode, bias and calibration flags leave through flip-flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      zero_current_pwm_mode_o <= 1'b0;
      pwm_bias_en_o <= 1'b0;
      calibrating_o <= 1'b0;
    end
    else
    begin
      zero_current_pwm_mode_o <= zcd_mode; // R6 R16
      pwm_bias_en_o <= bias_on; // R11 R12
      calibrating_o <= cal_busy; // R9
    end
  end

  // Gate sequencer state
  phase_t phase;
  phase_t next_phase;
  logic [CW-1:0] tmr;
  logic [CW-1:0] next_tmr;
  logic hs_cmd;
  logic ls_cmd;

  // Next-state and timer logic
  always_comb
  begin
    next_phase = phase;
    next_tmr = (tmr != '0) ? tmr - CW'(1) : tmr;
    if (!enabled)
    begin
      next_phase = ST_OFF; // R18
      next_tmr = '0;
    end
    else
    begin
      unique case (phase)
        ST_OFF, ST_LS_ON, ST_ZCD_WATCH:
        begin
          if (pwm == gate_seq_pkg::LEVEL_HIGH)
          begin
            if (phase == ST_LS_ON || phase == ST_ZCD_WATCH)
            begin
              next_phase = ST_LS_TURNOFF; // R1
              next_tmr = CW'(LOW_SIDE_OFF_CYCLES);
            end
            else
            begin
              next_phase = ST_HS_WAIT;
              next_tmr = CW'(HIGH_SIDE_ON_CYCLES);
            end
          end
          // Low side already on out of the blanking watch: keep it on, no gap
          else if (pwm == gate_seq_pkg::LEVEL_LOW && phase == ST_ZCD_WATCH)
            next_phase = ST_LS_ON; // R10
          else if (pwm == gate_seq_pkg::LEVEL_LOW && phase == ST_OFF)
          begin
            next_phase = ST_LS_WAIT; // R10
            next_tmr = CW'(LOW_SIDE_ON_CYCLES);
          end
          else if (pwm == gate_seq_pkg::LEVEL_MID)
          begin
            if (!zcd_mode)
              next_phase = ST_OFF; // R17
            else if (phase == ST_OFF && (mon.zero_current_detect || tmr != '0))
              next_phase = ST_OFF;
            else if (phase == ST_LS_ON)
            begin
              next_phase = ST_ZCD_WATCH; // R7
              next_tmr = CW'(BLANK_CYCLES);
            end
            else if (phase == ST_ZCD_WATCH && tmr == '0 && mon.zero_current_detect)
              next_phase = ST_OFF; // R8
          end
        end
        ST_LS_TURNOFF:
        begin
          // Wait for the low-side gate to be seen off before the high-side delay
          if (tmr == '0 && !ls_conducting)
          begin
            next_phase = ST_HS_WAIT; // R2
            next_tmr = CW'(HIGH_SIDE_ON_CYCLES);
          end
        end
        ST_HS_WAIT:
        begin
          if (pwm != gate_seq_pkg::LEVEL_HIGH)
            next_phase = ST_HS_TURNOFF;
          else if (tmr == '0 && !ls_conducting)
            next_phase = ST_HS_ON; // R2
        end
        ST_HS_ON:
        begin
          if (pwm != gate_seq_pkg::LEVEL_HIGH)
          begin
            next_phase = ST_HS_TURNOFF; // R3
            next_tmr = CW'(HIGH_SIDE_OFF_CYCLES);
          end
        end
        ST_HS_TURNOFF:
        begin
          // High side dropped; wait until it has stopped conducting
          if (tmr == '0 && !hs_conducting)
          begin
            if (pwm == gate_seq_pkg::LEVEL_MID && !zcd_mode)
              next_phase = ST_OFF; // R17
            else if (pwm == gate_seq_pkg::LEVEL_HIGH)
            begin
              next_phase = ST_HS_WAIT;
              next_tmr = CW'(HIGH_SIDE_ON_CYCLES);
            end
            else
            begin
              next_phase = ST_LS_WAIT; // R4
              next_tmr = CW'(LOW_SIDE_ON_CYCLES);
            end
          end
        end
        ST_LS_WAIT:
        begin
          if (pwm == gate_seq_pkg::LEVEL_HIGH)
            next_phase = ST_HS_WAIT;
          else if (pwm == gate_seq_pkg::LEVEL_MID && !zcd_mode)
            next_phase = ST_OFF; // R17
          else if (tmr == '0 && !hs_conducting)
          begin
            if (pwm == gate_seq_pkg::LEVEL_MID)
            begin
              next_phase = ST_ZCD_WATCH; // R7
              next_tmr = CW'(BLANK_CYCLES);
            end
            else
              next_phase = ST_LS_ON; // R4
          end
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase <= ST_OFF;
      tmr <= '0;
    end
    else
    begin
      phase <= next_phase;
      tmr <= next_tmr;
    end
  end

  // Gate commands registered from the next state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hs_cmd <= 1'b0;
      ls_cmd <= 1'b0;
    end
    else
    begin
      hs_cmd <= (next_phase == ST_HS_ON); // R13
      ls_cmd <= (next_phase == ST_LS_ON) || (next_phase == ST_ZCD_WATCH); // R7
    end
  end
  assign gate_o = '{high_side_gate: hs_cmd, low_side_gate: ls_cmd};

  // Avalon-MM slave: one wait cycle on every access, then answer
  logic acc_done;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      acc_done <= 1'b0;
    else
      acc_done <= (avs_read_i || avs_write_i) && !acc_done;
  end
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !acc_done;

  // Control register write with byte enables
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      control <= gate_seq_pkg::CTRL_RESET;
    else if (avs_write_i && acc_done && avs_address_i == gate_seq_pkg::REG_CONTROL)
    begin
      for (int b = 0; b < 4; b++)
        if (avs_byteenable_i[b])
          control[8*b +: 8] <= avs_writedata_i[8*b +: 8];
    end
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (avs_read_i && !acc_done)
    begin
      unique case (avs_address_i)
        gate_seq_pkg::REG_CONTROL: avs_readdata_o <= control;
        gate_seq_pkg::REG_STATUS: avs_readdata_o <= {26'h000_0000, pwm_bias_en_o, zcd_mode, calibrating_o,
                                                      enabled, ls_cmd, hs_cmd};
        gate_seq_pkg::REG_STATE: avs_readdata_o <= {29'h0000_0000, phase};
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ==== src/gate_seq_pkg.sv ====
// Notes on behaviour
// R1 - PWM high: drop low-side gate first
// R2 - Low-side confirmed off, delay, then high-side
// R3 - PWM low: drop high-side after delay; the code drops it at once and runs the delay afterwards
// R4 - High-side stopped, timer, then low-side on
// R5 - Conduction status from gate and switch levels
// R6 - Skip-mode high enables zero-current mode
// R7 - Mid-state: low-side on for blanking plus debounce
// R8 - After blanking, zero current ends low-side
// R9 - Enable rising edge runs 25 us calibration
// R10 - Three-level PWM sets high and low side
// R11 - Skip-mode mid engages PWM bias
// R12 - Skip-mode high or low: bias off
// R13 - Enable low or open blocks high-side
// R14 - Partner drives enable from logic or pull-up
// R15 - Stay disabled until supply lockout clears
// R16 - Skip-mode mid behaves as skip-mode high
// R17 - Skip low, PWM mid: both gates off now
// R18 - Lockout or disabled holds both gates low
// R19 - Pre-decoded levels, timers as cycle counters
package gate_seq_pkg;

  // Three-level input codes as delivered by the analog front end
  typedef enum logic [1:0] {
    LEVEL_LOW,
    LEVEL_MID,
    LEVEL_HIGH,
    LEVEL_BAD
  } level_t;

  // Monitored analog comparator outputs
  typedef struct packed {
    logic high_side_gate_level;
    logic low_side_gate_level;
    logic switch_node;
    logic zero_current_detect;
  } monitor_t;

  // Gate commands
  typedef struct packed {
    logic high_side_gate;
    logic low_side_gate;
  } gate_cmd_t;

  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PERIOD_PS = 50_000;

  // Times in ns and us as printed
  localparam int unsigned LOW_SIDE_OFF_DELAY_NS = 13;
  localparam int unsigned HIGH_SIDE_OFF_DELAY_NS = 47;
  localparam int unsigned HIGH_SIDE_ON_DELAY_NS = 13;
  localparam int unsigned LOW_SIDE_ON_DELAY_NS = 12;
  localparam int unsigned ZERO_CURRENT_BLANKING_TIME_NS = 250;
  localparam int unsigned DEBOUNCE_NS = 80;
  localparam int unsigned CALIBRATION_US = 25;

  function automatic int unsigned ns_to_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned LOW_SIDE_OFF_CYC = ns_to_cycles(LOW_SIDE_OFF_DELAY_NS);
  localparam int unsigned HIGH_SIDE_OFF_CYC = ns_to_cycles(HIGH_SIDE_OFF_DELAY_NS);
  localparam int unsigned HIGH_SIDE_ON_CYC = ns_to_cycles(HIGH_SIDE_ON_DELAY_NS);
  localparam int unsigned LOW_SIDE_ON_CYC = ns_to_cycles(LOW_SIDE_ON_DELAY_NS);
  localparam int unsigned BLANK_CYC = ns_to_cycles(ZERO_CURRENT_BLANKING_TIME_NS + DEBOUNCE_NS);
  localparam int unsigned CALIBRATION_CYC = (CALIBRATION_US * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Register offsets (byte addresses, one word each)
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_STATE = 4'h8;

  // Control register fields
  localparam int unsigned CTRL_FORCE_OFF_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Status register fields
  localparam int unsigned ST_HS_BIT = 0;
  localparam int unsigned ST_LS_BIT = 1;
  localparam int unsigned ST_ENABLED_BIT = 2;
  localparam int unsigned ST_CAL_BIT = 3;
  localparam int unsigned ST_ZCD_MODE_BIT = 4;
  localparam int unsigned ST_BIAS_BIT = 5;

endpackage

// ==== verif/gate_seq_chk.sv ====
`timescale 1ns/10ps
module gate_seq_chk #(
  parameter int unsigned BLANK_CYCLES = 7,
  parameter int unsigned CALIBRATION_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire gate_seq_pkg::level_t pwm_level_i,
  input wire gate_seq_pkg::level_t skip_mode_n_i,
  input wire logic driver_enable_n_i,
  input wire logic driver_enable_open_i,
  input wire logic supply_ok_i,
  input wire gate_seq_pkg::monitor_t monitor_i,
  input wire gate_seq_pkg::gate_cmd_t gate_o,
  input wire logic pwm_bias_en_o,
  input wire logic zero_current_pwm_mode_o,
  input wire logic calibrating_o
);
  logic run;
  logic sl;
  logic [7:0] mid_cnt;
  logic [15:0] cal_cnt;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Pin conditions
  assign run = supply_ok_i && driver_enable_n_i && !driver_enable_open_i;
  assign sl = skip_mode_n_i == gate_seq_pkg::LEVEL_LOW;
  // Cycles spent in mid-state with zero-current mode on
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run || sl || pwm_level_i != gate_seq_pkg::LEVEL_MID)
      mid_cnt <= 8'h00;
    else if (mid_cnt != 8'hff)
      mid_cnt <= mid_cnt + 8'h01;
  end
  // Length of the running calibration
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !calibrating_o)
      cal_cnt <= 16'h0000;
    else
      cal_cnt <= cal_cnt + 16'h0001;
  end
  sequence zcd_held;
    monitor_i.zero_current_detect [*4];
  endsequence
  sequence stopped;
    !run [*5];
  endsequence
  AST_NO_OVERLAP: assert property (!(gate_o.high_side_gate && gate_o.low_side_gate))
    else $error("both gates on");
  AST_HS_ON: assert property ($rose(gate_o.high_side_gate) |->
    !monitor_i.low_side_gate_level && $past(monitor_i.low_side_gate_level) == 1'b0) else $error("high early");
  AST_LS_ON: assert property ($rose(gate_o.low_side_gate) |->
    !monitor_i.high_side_gate_level && !monitor_i.switch_node) else $error("low early");
  AST_PWM_LOW: assert property ($rose(pwm_level_i == gate_seq_pkg::LEVEL_LOW) |->
    ##[1:8] !gate_o.high_side_gate) else $error("high not dropped");
  AST_OFF: assert property (stopped |-> gate_o == 2'b00) else $error("gate on while off");
  AST_SKIP_LOW_MID: assert property ((sl && pwm_level_i == gate_seq_pkg::LEVEL_MID) [*5] |->
    gate_o == 2'b00) else $error("gate on in skip low mid");
  AST_MODE: assert property (($stable(skip_mode_n_i)) [*4] |-> zero_current_pwm_mode_o == !sl &&
    pwm_bias_en_o == (skip_mode_n_i == gate_seq_pkg::LEVEL_MID)) else $error("skip decode");
  AST_CAL_LEN: assert property ($fell(calibrating_o) |-> cal_cnt == CALIBRATION_CYCLES)
    else $error("calibration length");
  AST_BLANK: assert property ($fell(gate_o.low_side_gate) && mid_cnt != 8'h00 |->
    mid_cnt > BLANK_CYCLES) else $error("blanking cut short");
  AST_ZCD_END: assert property (zcd_held ##0 mid_cnt > BLANK_CYCLES + 20 |->
    ##[1:3] !gate_o.low_side_gate) else $error("low kept after zero current");
endmodule

bind gate_drive_sequencer gate_seq_chk #(.BLANK_CYCLES(BLANK_CYCLES), .CALIBRATION_CYCLES(CALIBRATION_CYCLES)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .pwm_level_i(pwm_level_i), .skip_mode_n_i(skip_mode_n_i),
  .driver_enable_n_i(driver_enable_n_i), .driver_enable_open_i(driver_enable_open_i),
  .supply_ok_i(supply_ok_i), .monitor_i(monitor_i), .gate_o(gate_o), .pwm_bias_en_o(pwm_bias_en_o),
  .zero_current_pwm_mode_o(zero_current_pwm_mode_o), .calibrating_o(calibrating_o));

// ==== verif/power_stage_model.sv ====
`timescale 1ns/10ps
module power_stage_model (
  input wire logic clk_i,
  input wire gate_seq_pkg::gate_cmd_t gate_i,
  input wire logic slow_i,
  input wire logic zero_i,
  output gate_seq_pkg::monitor_t monitor_o
);
  logic [2:0] hs;
  logic [2:0] ls;
  // Gate levels trail the commands, by three cycles when slow
  always @(posedge clk_i)
  begin
    hs <= {hs[1:0], gate_i.high_side_gate};
    ls <= {ls[1:0], gate_i.low_side_gate};
  end
  // Switch node follows the high-side switch
  assign monitor_o.high_side_gate_level = slow_i ? hs[2] : hs[0];
  assign monitor_o.switch_node = slow_i ? hs[2] : hs[0];
  assign monitor_o.low_side_gate_level = slow_i ? ls[2] : ls[0];
  assign monitor_o.zero_current_detect = zero_i;
endmodule

// ==== verif/tristate_gate_drive_sequencer_test.sv ====
`timescale 1ns/10ps
module tristate_gate_drive_sequencer_test;
  localparam int unsigned BLANK = gate_seq_pkg::BLANK_CYC;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  gate_seq_pkg::level_t pwm = gate_seq_pkg::LEVEL_LOW;
  gate_seq_pkg::level_t skip = gate_seq_pkg::LEVEL_HIGH;
  logic en_n = 1'b0;
  logic en_open = 1'b0;
  logic sup = 1'b0;
  logic slow = 1'b0;
  logic zero = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [31:0] seed = 32'h0001_0ede;
  logic wreq;
  logic bias;
  logic zmode;
  logic cal;
  gate_seq_pkg::monitor_t mon;
  gate_seq_pkg::gate_cmd_t gate;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  // Clock, 50 ns period
  always #25 clk_i = ~clk_i;
  // Short counts keep the run brief
  gate_drive_sequencer #(.LOW_SIDE_OFF_CYCLES(2), .HIGH_SIDE_OFF_CYCLES(3), .HIGH_SIDE_ON_CYCLES(2),
    .LOW_SIDE_ON_CYCLES(2), .CALIBRATION_CYCLES(20)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .pwm_level_i(pwm), .skip_mode_n_i(skip), .driver_enable_n_i(en_n),
    .driver_enable_open_i(en_open), .supply_ok_i(sup), .monitor_i(mon), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .gate_o(gate), .pwm_bias_en_o(bias),
    .zero_current_pwm_mode_o(zmode), .calibrating_o(cal));
  power_stage_model stage (.clk_i(clk_i), .gate_i(gate), .slow_i(slow), .zero_i(zero), .monitor_o(mon));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Settled gates for a pwm code, zero current already seen in mid-state
  function automatic gate_seq_pkg::gate_cmd_t exp_gate(input int p);
    return (p == 2) ? 2'b10 : (p == 0) ? 2'b01 : 2'b00;
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  task automatic chk_gate(input gate_seq_pkg::gate_cmd_t e);
    checked++;
    if (gate !== e)
    begin
      error_cnt++;
      $display("[FAIL] gate_o expected %b seen %b", e, gate);
    end
  endtask
  task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic apply(input int p, input int s);
    pwm <= gate_seq_pkg::level_t'(p);
    skip <= gate_seq_pkg::level_t'(s);
    tick(40);
    chk_gate(exp_gate(p));
  endtask
  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wreq !== 1'b0 && k < 20);
    chk_word("waitrequest", 0, wreq);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic done_test(input string name);
    $display("test %s done, mismatches so far %0d", name, error_cnt);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  initial
  begin
    tick(12);
    rst_i <= 1'b0;
    tick(3);
    chk_gate(2'b00);
    sup <= 1'b1;
    tick(10);
    chk_gate(2'b00);
    en_n <= 1'b1;
    tick(6);
    chk_word("calibrating", 1, cal);
    tick(25);
    chk_word("calibrating", 0, cal);
    done_test("startup");
    for (int i = 0; i < 3; i++)
    begin
      skip <= gate_seq_pkg::level_t'(i);
      tick(5);
      chk_word("bias", i == 1, bias);
      chk_word("zcd_mode", i != 0, zmode);
    end
    for (int i = 0; i < 8; i++)
    begin
      slow <= i[2];
      apply((i % 2 == 0) ? 2 : 0, 2);
    end
    zero <= 1'b0;
    pwm <= gate_seq_pkg::LEVEL_MID;
    tick(BLANK + 1);
    chk_gate(2'b01);
    tick(20);
    chk_gate(2'b01);
    zero <= 1'b1;
    tick(8);
    chk_gate(2'b00);
    apply(2, 2);
    pwm <= gate_seq_pkg::LEVEL_MID;
    n = 0;
    repeat (40)
    begin
      tick(1);
      n += (gate.low_side_gate === 1'b1);
    end
    chk_word("low_on_ok", 1, n >= BLANK && n <= BLANK + 3);
    done_test("zero_current");
    apply(0, 0);
    pwm <= gate_seq_pkg::LEVEL_MID;
    tick(4);
    chk_gate(2'b00);
    apply(2, 2);
    en_n <= 1'b0;
    tick(5);
    chk_gate(2'b00);
    en_n <= 1'b1;
    tick(6);
    chk_word("calibrating", 1, cal);
    tick(40);
    en_open <= 1'b1;
    tick(5);
    chk_gate(2'b00);
    en_open <= 1'b0;
    sup <= 1'b0;
    tick(5);
    chk_gate(2'b00);
    sup <= 1'b1;
    tick(60);
    chk_gate(2'b10);
    done_test("disable");
    bus(0, gate_seq_pkg::REG_CONTROL, 0);
    chk_word("control", gate_seq_pkg::CTRL_RESET, q);
    bus(0, gate_seq_pkg::REG_STATUS, 0);
    chk_word("status", 32'h0000_0015, q & 32'h0000_003f);
    bus(1, 4'hc, 32'hffff_ffff);
    bus(0, 4'hc, 0);
    chk_word("unmapped", 0, q);
    bus(1, gate_seq_pkg::REG_CONTROL, 1);
    tick(5);
    chk_gate(2'b00);
    bus(0, gate_seq_pkg::REG_STATE, 0);
    chk_word("state", 0, q);
    bus(0, gate_seq_pkg::REG_CONTROL, 0);
    chk_word("control", 1, q);
    // Lane zero masked: the force-off bit must survive the write
    be <= 4'he;
    bus(1, gate_seq_pkg::REG_CONTROL, 32'h1234_5600);
    bus(0, gate_seq_pkg::REG_CONTROL, 0);
    chk_word("control_lanes", 32'h1234_5601, q);
    be <= 4'hf;
    bus(1, gate_seq_pkg::REG_CONTROL, 0);
    tick(10);
    chk_gate(2'b10);
    done_test("registers");
    repeat (40)
    begin
      q = rnd();
      slow <= q[8];
      apply(q % 3, (q >> 4) % 3);
    end
    done_test("random");
    give_verdict();
  end
endmodule
